// ===== design/stp_prescaler.sv
// Purpose: shared free-running prescaler and count clock select for two timers
// Assumes: AHB-Lite slave, single word transfers, zero wait states
// Notes:   timer counters themselves live outside this block
//
// Function
// R1: select 1 counts every system clock
// R2: taps at divide 8, 64, 256, 1024
// R3: one free-running prescaler serves both timers
// R4: first prescaled count within 1..N+1 clocks
// R5: prescaler reset restarts shared count
// R6: pin sampled each clock, fed to edge detector
// R7: latch transparent on high, then rising registers
// R8: pulse on rise for 7, fall for 6
// R9: pin edge to update 2.5 to 3.5 clocks
// R10: other side changes select only when pin stable
// R11: external clock half period above one clock
// R12: external clock kept below clock over 2.5
// R13: pin pulses never pass through the divider
// R14: sync mode holds written prescaler reset bit
// R15: clearing sync mode clears prescaler reset bit
// R16: reset bit self-clears unless sync mode set
// R17: control bits 6..1 read zero
// R18: pin counts even when driven as output
// R19: system reset clears prescaler and control bits
//
// Decided for this implementation: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module stp_prescaler (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        external_count_pin_0,
  input  wire logic        external_count_pin_1,
  output logic             timer_count_pulse_0,
  output logic             timer_count_pulse_1
);
  localparam int PW = stp_pkg::STP_PRESC_W;

  // bus address phase capture
  logic       wr_pend;
  logic       rd_pend;
  logic [7:0] a_addr;
  logic       prescaler_reset_bit;
  logic       sync_hold_mode;
  logic [2:0] csel0;
  logic [2:0] csel1;
  logic [PW-1:0] presc;
  logic       rst_hold;

  wire logic a_valid = hsel && hready && htrans[1];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      a_addr  <= 8'h00;
    end else begin
      wr_pend <= a_valid && hwrite;
      rd_pend <= a_valid && !hwrite;
      if (a_valid) begin
        a_addr <= haddr[7:0];
      end
    end
  end

  wire logic wr_gtc  = wr_pend && (a_addr == stp_pkg::STP_ADDR_GTC);
  wire logic wr_csel = wr_pend && (a_addr == stp_pkg::STP_ADDR_CSEL);

  // control bits; prescaler reset self-clears unless held by sync mode
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync_hold_mode      <= stp_pkg::STP_GTC_RESET_VAL[stp_pkg::STP_GTC_SYNC_BIT]; // R19
      prescaler_reset_bit <= stp_pkg::STP_GTC_RESET_VAL[stp_pkg::STP_GTC_RESET_BIT]; // R19
    end else if (wr_gtc) begin
      sync_hold_mode      <= hwdata[stp_pkg::STP_GTC_SYNC_BIT];
      // written one is kept only while sync mode is set; zero sync clears it
      prescaler_reset_bit <= hwdata[stp_pkg::STP_GTC_RESET_BIT]
                             && hwdata[stp_pkg::STP_GTC_SYNC_BIT]; // R14 R15 R16
    end else if (!sync_hold_mode) begin
      prescaler_reset_bit <= 1'b0; // R16
    end
  end

  // a one written without sync mode still resets the prescaler for one cycle
  assign rst_hold = prescaler_reset_bit
                    || (wr_gtc && hwdata[stp_pkg::STP_GTC_RESET_BIT]); // R5 R16

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      csel0 <= stp_pkg::STP_CS_STOP;
      csel1 <= stp_pkg::STP_CS_STOP;
    end else if (wr_csel) begin
      csel0 <= hwdata[2:0];
      csel1 <= hwdata[10:8];
    end
  end

  // free running regardless of selection; only its own reset stops it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      presc <= '0; // R19
    end else if (rst_hold) begin
      presc <= '0; // R5
    end else begin
      presc <= presc + 1'b1; // R3 R4
    end
  end

  // pin front end: latch open while clock high, then rising flops.
  // the pin is read as an input whatever its direction, so self-driven
  // transitions count too.
  logic [1:0] pin_lat;
  logic [1:0] pin_s1;
  logic [1:0] pin_s2;
  always_latch begin
    if (hclk) begin
      pin_lat = {external_count_pin_1, external_count_pin_0}; // R7 R18
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_s1 <= 2'b00;
      pin_s2 <= 2'b00;
    end else begin
      pin_s1 <= pin_lat; // R6 R7
      pin_s2 <= pin_s1; // R9
    end
  end

  wire logic [1:0] rise = pin_s1 & ~pin_s2; // R6 R9
  wire logic [1:0] fall = ~pin_s1 & pin_s2;

  // held prescaler reset halts prescaled timers; direct and pin modes run
  stp_sel_if u_if0 ();
  stp_sel_if u_if1 ();
  assign u_if0.count_clock_select = csel0;
  assign u_if1.count_clock_select = csel1;
  assign u_if0.presc    = rst_hold ? '0 : presc;
  assign u_if1.presc    = rst_hold ? '0 : presc;
  assign u_if0.pin_rise = rise[0];
  assign u_if0.pin_fall = fall[0];
  assign u_if1.pin_rise = rise[1];
  assign u_if1.pin_fall = fall[1];

  stp_sel u_sel0 (
    .s (u_if0.sel)
  );
  stp_sel u_sel1 (
    .s (u_if1.sel)
  );
  assign timer_count_pulse_0 = u_if0.timer_count_pulse;
  assign timer_count_pulse_1 = u_if1.timer_count_pulse;

  // read data registered from the address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (a_valid && !hwrite) begin
      case (haddr[7:0])
        stp_pkg::STP_ADDR_GTC:
          hrdata <= {24'h000000, sync_hold_mode, 6'h00, prescaler_reset_bit}; // R17
        stp_pkg::STP_ADDR_CSEL:
          hrdata <= {21'h0, csel1, 5'h00, csel0};
        stp_pkg::STP_ADDR_STATUS:
          hrdata <= {22'h0, presc};
        default:
          hrdata <= 32'h00000000;
      endcase
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // assertion helpers: tap decode shared by several checks
  function automatic logic is_tap(input logic [2:0] cs);
    is_tap = (cs >= stp_pkg::STP_CS_DIV8) && (cs <= stp_pkg::STP_CS_DIV1024);
  endfunction

  function automatic logic [PW-1:0] tap_span(input logic [2:0] cs);
    case (cs)
      stp_pkg::STP_CS_DIV8:    tap_span = stp_pkg::STP_TAP8_MASK;
      stp_pkg::STP_CS_DIV64:   tap_span = stp_pkg::STP_TAP64_MASK;
      stp_pkg::STP_CS_DIV256:  tap_span = stp_pkg::STP_TAP256_MASK;
      stp_pkg::STP_CS_DIV1024: tap_span = stp_pkg::STP_TAP1024_MASK;
      default:                 tap_span = '0;
    endcase
  endfunction

  // gap counters measure pulse spacing independently of the prescaler;
  // a select write restarts the measure, so the first pulse is only bounded
  logic [PW-1:0] gap0;
  logic [PW-1:0] gap1;
  logic          arm0;
  logic          arm1;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gap0 <= '0;
      arm0 <= 1'b0;
    end else if (wr_csel) begin
      gap0 <= '0;
      arm0 <= 1'b0;
    end else if (rst_hold || timer_count_pulse_0) begin
      gap0 <= '0;
      arm0 <= 1'b1;
    end else begin
      gap0 <= gap0 + 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gap1 <= '0;
      arm1 <= 1'b0;
    end else if (wr_csel) begin
      gap1 <= '0;
      arm1 <= 1'b0;
    end else if (rst_hold || timer_count_pulse_1) begin
      gap1 <= '0;
      arm1 <= 1'b1;
    end else begin
      gap1 <= gap1 + 1'b1;
    end
  end

  // assertions
  AST_DIRECT: assert property (@(posedge hclk) disable iff (!hresetn) // R1
    (csel0 == stp_pkg::STP_CS_DIRECT) |-> timer_count_pulse_0)
    else $error("direct select did not pulse");

  AST_DIRECT1: assert property (@(posedge hclk) disable iff (!hresetn) // R1
    (csel1 == stp_pkg::STP_CS_DIRECT) |-> timer_count_pulse_1)
    else $error("timer 1 direct select did not pulse");

  AST_STOP0: assert property (@(posedge hclk) disable iff (!hresetn) // R3
    (csel0 == stp_pkg::STP_CS_STOP) |-> !timer_count_pulse_0)
    else $error("timer 0 pulsed while stopped");

  AST_STOP1: assert property (@(posedge hclk) disable iff (!hresetn) // R3
    (csel1 == stp_pkg::STP_CS_STOP) |-> !timer_count_pulse_1)
    else $error("timer 1 pulsed while stopped");

  AST_DIV8: assert property (@(posedge hclk) disable iff (!hresetn) // R2
    (csel0 == stp_pkg::STP_CS_DIV8 && timer_count_pulse_0 && !rst_hold
     && $stable(csel0) && !wr_gtc) |=> !timer_count_pulse_0 [*7])
    else $error("divide by 8 pulses too close");

  AST_TAPGAP0: assert property (@(posedge hclk) disable iff (!hresetn) // R2
    (is_tap(csel0) && arm0 && timer_count_pulse_0) |-> gap0 == tap_span(csel0))
    else $error("timer 0 tap spacing wrong");

  AST_TAPGAP1: assert property (@(posedge hclk) disable iff (!hresetn) // R2
    (is_tap(csel1) && arm1 && timer_count_pulse_1) |-> gap1 == tap_span(csel1))
    else $error("timer 1 tap spacing wrong");

  AST_FIRST0: assert property (@(posedge hclk) disable iff (!hresetn) // R4
    (is_tap(csel0) && !rst_hold) |-> gap0 <= tap_span(csel0))
    else $error("timer 0 tap pulse overdue");

  AST_FIRST1: assert property (@(posedge hclk) disable iff (!hresetn) // R4
    (is_tap(csel1) && !rst_hold) |-> gap1 <= tap_span(csel1))
    else $error("timer 1 tap pulse overdue");

  AST_FREE: assert property (@(posedge hclk) disable iff (!hresetn) // R3
    !rst_hold |=> presc == $past(presc) + 1'b1)
    else $error("prescaler did not advance");

  AST_PRESET: assert property (@(posedge hclk) disable iff (!hresetn) // R5
    rst_hold |=> presc == '0)
    else $error("prescaler reset ignored");

  // pin edges as seen after the first sampling stage
  sequence s_rise_seen;
    !pin_s1[0] ##1 pin_s1[0];
  endsequence

  sequence s_fall_seen0;
    pin_s1[0] ##1 !pin_s1[0];
  endsequence

  sequence s_rise_seen1;
    !pin_s1[1] ##1 pin_s1[1];
  endsequence

  sequence s_fall_seen1;
    pin_s1[1] ##1 !pin_s1[1];
  endsequence

  AST_RISE: assert property (@(posedge hclk) disable iff (!hresetn) // R8
    s_rise_seen ##0 (csel0 == stp_pkg::STP_CS_EXT_RISE) |-> timer_count_pulse_0)
    else $error("rising pin edge missed");

  AST_FALLSEEN0: assert property (@(posedge hclk) disable iff (!hresetn) // R8 R13
    s_fall_seen0 ##0 (csel0 == stp_pkg::STP_CS_EXT_FALL) |-> timer_count_pulse_0)
    else $error("timer 0 falling pin edge missed");

  AST_RISE1: assert property (@(posedge hclk) disable iff (!hresetn) // R8 R13
    s_rise_seen1 ##0 (csel1 == stp_pkg::STP_CS_EXT_RISE) |-> timer_count_pulse_1)
    else $error("timer 1 rising pin edge missed");

  AST_FALLSEEN1: assert property (@(posedge hclk) disable iff (!hresetn) // R8 R13
    s_fall_seen1 ##0 (csel1 == stp_pkg::STP_CS_EXT_FALL) |-> timer_count_pulse_1)
    else $error("timer 1 falling pin edge missed");

  AST_FALL: assert property (@(posedge hclk) disable iff (!hresetn) // R8
    (csel0 == stp_pkg::STP_CS_EXT_FALL && timer_count_pulse_0) |-> !pin_s1[0] && pin_s2[0])
    else $error("falling pulse without falling edge");

  AST_HOLD: assert property (@(posedge hclk) disable iff (!hresetn) // R14
    (sync_hold_mode && prescaler_reset_bit && !wr_gtc) |=> prescaler_reset_bit)
    else $error("held reset bit dropped");

  AST_SELFCLR: assert property (@(posedge hclk) disable iff (!hresetn) // R16
    (!sync_hold_mode && !wr_gtc) |=> !prescaler_reset_bit)
    else $error("reset bit did not self clear");

  // only a release that ends an active reset restarts the count at one
  AST_RELEASE: assert property (@(posedge hclk) disable iff (!hresetn) // R15
    (wr_gtc && rst_hold && !hwdata[stp_pkg::STP_GTC_SYNC_BIT])
    |=> !prescaler_reset_bit ##1 presc == 10'h001)
    else $error("sync release did not restart prescaler");

  AST_OKAY: assert property (@(posedge hclk) disable iff (!hresetn)
    hreadyout && !hresp)
    else $error("slave not ready or not okay");

  AST_RDHOLD: assert property (@(posedge hclk) disable iff (!hresetn)
    !(a_valid && !hwrite) |=> $stable(hrdata))
    else $error("read data moved without a read");

  AST_RSVD: assert property (@(posedge hclk) disable iff (!hresetn) // R17
    $rose(rd_pend) && a_addr == stp_pkg::STP_ADDR_GTC |-> hrdata[6:1] == 6'h00)
    else $error("reserved bits not zero");
endmodule // stp_prescaler

// ===== design/stp_sel.sv
// Purpose: picks one timer's count pulse from direct, tap or pin edge
// Assumes: prescaler count and pin edges come from the shared core
// Notes:   pulse is combinational, one clock wide
`timescale 1ns/1ps
module stp_sel (
  stp_sel_if.sel s
);
  function automatic logic tap_hit(input logic [9:0] cnt, input logic [9:0] mask);
    tap_hit = ((cnt & mask) == mask);
  endfunction

  always_comb begin
    case (s.count_clock_select)
      stp_pkg::STP_CS_STOP:     s.timer_count_pulse = 1'b0;
      stp_pkg::STP_CS_DIRECT:   s.timer_count_pulse = 1'b1; // R1
      stp_pkg::STP_CS_DIV8:     s.timer_count_pulse = tap_hit(s.presc, stp_pkg::STP_TAP8_MASK); // R2
      stp_pkg::STP_CS_DIV64:    s.timer_count_pulse = tap_hit(s.presc, stp_pkg::STP_TAP64_MASK);
      stp_pkg::STP_CS_DIV256:   s.timer_count_pulse = tap_hit(s.presc, stp_pkg::STP_TAP256_MASK);
      stp_pkg::STP_CS_DIV1024:  s.timer_count_pulse = tap_hit(s.presc, stp_pkg::STP_TAP1024_MASK);
      // pin pulses bypass the divider
      stp_pkg::STP_CS_EXT_FALL: s.timer_count_pulse = s.pin_fall; // R8 R13
      stp_pkg::STP_CS_EXT_RISE: s.timer_count_pulse = s.pin_rise; // R8 R13
      default:                  s.timer_count_pulse = 1'b0;
    endcase
  end
endmodule // stp_sel

// ===== pkg/stp_pkg.sv
// Purpose: constants for the shared timer prescaler
// Assumes: 32-bit AHB-Lite register access, one word per register
// Notes:   offsets are byte addresses
package stp_pkg;
  localparam logic [7:0]  STP_ADDR_GTC      = 8'h00;
  localparam logic [7:0]  STP_ADDR_CSEL     = 8'h04;
  localparam logic [7:0]  STP_ADDR_STATUS   = 8'h08;
  localparam int          STP_GTC_RESET_BIT = 0;
  localparam int          STP_GTC_SYNC_BIT  = 7;
  localparam logic [7:0]  STP_GTC_RESET_VAL = 8'h00;
  localparam logic [2:0]  STP_CS_STOP       = 3'h0;
  localparam logic [2:0]  STP_CS_DIRECT     = 3'h1;
  localparam logic [2:0]  STP_CS_DIV8       = 3'h2;
  localparam logic [2:0]  STP_CS_DIV64      = 3'h3;
  localparam logic [2:0]  STP_CS_DIV256     = 3'h4;
  localparam logic [2:0]  STP_CS_DIV1024    = 3'h5;
  localparam logic [2:0]  STP_CS_EXT_FALL   = 3'h6;
  localparam logic [2:0]  STP_CS_EXT_RISE   = 3'h7;
  localparam int          STP_PRESC_W       = 10;
  localparam logic [9:0]  STP_TAP8_MASK     = 10'h007;
  localparam logic [9:0]  STP_TAP64_MASK    = 10'h03f;
  localparam logic [9:0]  STP_TAP256_MASK   = 10'h0ff;
  localparam logic [9:0]  STP_TAP1024_MASK  = 10'h3ff;
  localparam int          STP_CLK_NS        = 50;
  localparam int          STP_SYNC_DLY_MIN  = 2;
  localparam int          STP_SYNC_DLY_MAX  = 3;
endpackage

// ===== pkg/stp_sel_if.sv
// Purpose: carries one timer's count pulse selection to the selector
// Assumes: single clock domain
// Notes:   none
`timescale 1ns/1ps
interface stp_sel_if;
  logic [2:0] count_clock_select;
  logic [9:0] presc;
  logic       pin_rise;
  logic       pin_fall;
  logic       timer_count_pulse;
  modport core (output count_clock_select, output presc, output pin_rise,
                output pin_fall, input timer_count_pulse);
  modport sel  (input count_clock_select, input presc, input pin_rise,
                input pin_fall, output timer_count_pulse);
endinterface

// ===== verification/stp_ext_src.sv
// Purpose: external count source standing on one timer pin
// Assumes: bench clock, pin changes just after a rising edge
// Notes:   idles at its last level while stopped
`timescale 1ns/1ps
module stp_ext_src #(
  parameter int HALF = 3
) (
  input  wire logic hclk,
  input  wire logic run,
  output logic      pin
);
  int n = 0;
  initial pin = 1'b0;
  // three clocks a level keeps it well under clock/2.5
  always @(posedge hclk) begin
    if (!run) begin
      n <= 0;
    end else if (n == HALF - 1) begin
      n   <= 0;
      pin <= ~pin;
    end else begin
      n <= n + 1;
    end
  end
endmodule // stp_ext_src

// ===== verification/stp_prescaler_tb.sv
// Purpose: self-checking bench for the shared timer prescaler
// Assumes: zero wait AHB-Lite slave, hready tied to hreadyout
// Notes:   pulses counted every edge, windows taken as differences
`timescale 1ns/1ps
module stp_prescaler_tb;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic        hreadyout, hresp, pin0, pin1, pls0, pls1, p0q, p1q;
  logic        run = 1'b0;
  logic [31:0] q;
  int          mismatches = 0, n_compared = 0, c0 = 0, c1 = 0, r0 = 0, f1 = 0;
  int          a0, a1, b0, b1, i;

  initial forever #25 hclk = ~hclk;

  stp_prescaler DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .external_count_pin_0(pin0), .external_count_pin_1(pin1),
    .timer_count_pulse_0(pls0), .timer_count_pulse_1(pls1));
  stp_ext_src u_src0 (.hclk(hclk), .run(run), .pin(pin0));
  stp_ext_src u_src1 (.hclk(hclk), .run(run), .pin(pin1));

  always @(posedge hclk) begin
    c0  <= c0 + int'(pls0 === 1'b1);
    c1  <= c1 + int'(pls1 === 1'b1);
    r0  <= r0 + int'(pin0 && !p0q);
    f1  <= f1 + int'(!pin1 && p1q);
    p0q <= pin0;
    p1q <= pin1;
  end

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask

  task window(input int n);
    // skip the edge that loads the new select
    @(posedge hclk);
    a0 = c0;
    a1 = c1;
    repeat (n) @(posedge hclk);
    b0 = c0 - a0;
    b1 = c1 - a1;
  endtask

  task t_regs;
    xfer(stp_pkg::STP_ADDR_GTC, 1'b0, 32'h0);
    chk(q, 32'h0);
    chk(hresp, 1'b0);
    chk(hreadyout, 1'b1);
    xfer(8'h0c, 1'b0, 32'h0);
    chk(q, 32'h0);
    xfer(stp_pkg::STP_ADDR_GTC, 1'b1, 32'h1);
    xfer(stp_pkg::STP_ADDR_GTC, 1'b0, 32'h0);
    chk(q, 32'h0);
  endtask

  task t_direct_taps;
    xfer(stp_pkg::STP_ADDR_CSEL, 1'b1, 32'h0);
    window(16);
    chk(b0 + b1, 0);
    xfer(stp_pkg::STP_ADDR_CSEL, 1'b1, 32'h101);
    window(16);
    chk(b0, 16);
    chk(b1, 16);
    xfer(stp_pkg::STP_ADDR_CSEL, 1'b1, 32'h302);
    window(128);
    chk(b0, 16);
    chk(b1, 2);
    xfer(stp_pkg::STP_ADDR_GTC, 1'b1, 32'h1);
    i = 0;
    do begin
      @(posedge hclk);
      i++;
    end while (pls0 !== 1'b1 && i < 40);
    chk(i >= 7 && i <= 9, 1'b1);
  endtask

  task t_sync_ext;
    xfer(stp_pkg::STP_ADDR_GTC, 1'b1, 32'hff);
    xfer(stp_pkg::STP_ADDR_GTC, 1'b0, 32'h0);
    chk(q, 32'h81);
    xfer(stp_pkg::STP_ADDR_CSEL, 1'b1, 32'h202);
    window(40);
    chk(b0 + b1, 0);
    xfer(stp_pkg::STP_ADDR_STATUS, 1'b0, 32'h0);
    chk(q, 32'h0);
    // selects change only while both pins have been still for long
    xfer(stp_pkg::STP_ADDR_CSEL, 1'b1, 32'h607);
    repeat (4) @(posedge hclk);
    a0 = c0;
    a1 = c1;
    b0 = r0;
    b1 = f1;
    run <= 1'b1;
    repeat (60) @(posedge hclk);
    run <= 1'b0;
    repeat (8) @(posedge hclk);
    chk(r0 - b0, 10);
    chk(c0 - a0, r0 - b0);
    chk(c1 - a1, f1 - b1);
    xfer(stp_pkg::STP_ADDR_GTC, 1'b1, 32'h0);
    xfer(stp_pkg::STP_ADDR_GTC, 1'b0, 32'h0);
    chk(q, 32'h0);
    xfer(stp_pkg::STP_ADDR_CSEL, 1'b1, 32'h202);
    window(64);
    chk(b0, 8);
    chk(b1, 8);
  endtask

  task t_reset;
    xfer(stp_pkg::STP_ADDR_GTC, 1'b1, 32'h81);
    xfer(stp_pkg::STP_ADDR_CSEL, 1'b1, 32'h101);
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    chk(pls0 | pls1, 1'b0);
    hresetn <= 1'b1;
    @(posedge hclk);
    xfer(stp_pkg::STP_ADDR_GTC, 1'b0, 32'h0);
    chk(q, 32'h0);
    xfer(stp_pkg::STP_ADDR_CSEL, 1'b0, 32'h0);
    chk(q, 32'h0);
  endtask

  task results;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    #(50 * 4000);
    mismatches++;
    results();
  end

  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_regs();
    t_direct_taps();
    t_sync_ext();
    t_reset();
    results();
  end
endmodule // stp_prescaler_tb
